// [design/cpusr_pkg.sv]
/*
 * Constants for the processor supervisor reset block: timebase, reset hold,
 * debounce and watchdog figures.
 * Assumes a single 100 MHz clock; all slower rates are enable pulses.
 */
package cpusr_pkg;
    // ************************************************************
    // Clock and timebase
    // ************************************************************
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned TICK_HZ       = 32_768;
    // Timebase divider: longest period that does not exceed the tick
    localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_W        = 12;

    // ************************************************************
    // Reset timing, in timebase ticks
    // ************************************************************
    localparam int unsigned RST_HOLD_MS   = 250;
    // Least time: round up to whole ticks
    localparam int unsigned RST_HOLD_TK   = (RST_HOLD_MS * TICK_HZ + 999) / 1000;
    localparam int unsigned DEB_MS        = 10;
    localparam int unsigned DEB_TK        = (DEB_MS * TICK_HZ + 999) / 1000;
    localparam int unsigned WDT_MS        = 1600;
    localparam int unsigned WDT_TK        = (WDT_MS * TICK_HZ + 999) / 1000;
    localparam int unsigned CNT_W         = 20;

    // ************************************************************
    // States
    // ************************************************************
    typedef enum logic [1:0] {
        CPUSR_RUN,
        CPUSR_HOLD,
        CPUSR_RELEASE
    } cpusr_state_t;
endpackage : cpusr_pkg

// [design/cpusr_supervisor.sv]
/*
 * Processor supervisor reset: supply fail, pushbutton / shared reset pin and
 * watchdog drive one open-drain active-low reset pin.
 * Assumes inputs synchronous to mclk; the pin wire level is resolved outside
 * with a pull-up, and rst_pin_level reads that resolved level.
 * Limitation: a pin held low past a whole reset is taken as a fresh press,
 * so a stuck button resets the host again after every debounce time.
 */
// Operation
// RULE1 - Supply fault holds the reset output active for as long as it lasts.
// RULE2 - After supply recovers, reset stays active another 250 ms.
// RULE3 - Debounced pushbutton press gives a reset pulse of at least 250 ms.
// RULE4 - Watchdog expiry without a strobe forces reset active.
// RULE5 - Host must pull the strobe low before each watchdog timeout.
// RULE6 - Reset pin is open-drain; external low counts as a pushbutton press.
// RULE7 - Watchdog length is a parameter; each strobe falling edge restarts it.
`timescale 1ns/1ps
module cpusr_supervisor #(
    parameter logic [19:0] WDT_TICKS = 20'(cpusr_pkg::WDT_TK),
    parameter logic [19:0] HOLD_TICKS = 20'(cpusr_pkg::RST_HOLD_TK),
    parameter logic [19:0] DEB_TICKS = 20'(cpusr_pkg::DEB_TK)
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic supply_fail,
    input  wire logic wdt_strobe,
    input  wire logic rst_pin_level,
    output      logic rst_pin_data,
    output      logic rst_pin_oe,
    output      logic reset_active
);
    cpusr_tick_if tk ();

    cpusr_tick_div u_div (
        .mclk  (mclk),
        .rst_n (rst_n),
        .tk    (tk)
    );

    // ************************************************************
    // State and event nets
    // ************************************************************
    logic [cpusr_pkg::CNT_W-1:0] hold_ff;
    logic [cpusr_pkg::CNT_W-1:0] nxt_hold;
    logic [cpusr_pkg::CNT_W-1:0] deb_ff;
    logic [cpusr_pkg::CNT_W-1:0] nxt_deb;
    logic [cpusr_pkg::CNT_W-1:0] wdt_ff;
    logic [cpusr_pkg::CNT_W-1:0] nxt_wdt;
    cpusr_pkg::cpusr_state_t     state_ff;
    cpusr_pkg::cpusr_state_t     nxt_state;
    logic                        strobe_ff;
    logic                        nxt_strobe;
    logic                        drive_ff;
    logic                        nxt_drive;
    logic                        press;
    logic                        wdt_expire;
    logic                        strobe_fall;
    logic                        ext_low;
    logic                        deb_done;
    logic                        wdt_done;
    logic                        hold_done;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Counters saturate at their limit; >= keeps a count that sits at or
    // past the limit finished, so no count can wrap and fire twice
    function automatic logic cpusr_reached(
        input logic [cpusr_pkg::CNT_W-1:0] cnt,
        input logic [cpusr_pkg::CNT_W-1:0] lim
    );
        return cnt >= lim;
    endfunction : cpusr_reached

    // ************************************************************
    // Event detection
    // ************************************************************
    // Our own drive also pulls the pin low; only a low we are not making counts
    assign ext_low     = !rst_pin_level && !drive_ff;                  // RULE6
    assign strobe_fall = strobe_ff && !wdt_strobe;                     // RULE7
    // Terminal counts, shared by the counters and the sequencer
    assign deb_done    = cpusr_reached(deb_ff, DEB_TICKS);
    assign wdt_done    = cpusr_reached(wdt_ff, WDT_TICKS);
    assign hold_done   = cpusr_reached(hold_ff, HOLD_TICKS);
    assign press       = ext_low && deb_done;                          // RULE3
    assign wdt_expire  = (state_ff == cpusr_pkg::CPUSR_RUN) && wdt_done; // RULE4

    // ************************************************************
    // Strobe edge
    // ************************************************************
    // Last strobe level; resets high, the idle level, so no false edge follows
    always_comb begin
        nxt_strobe = wdt_strobe;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strobe_ff <= 1'b1;
        end else begin
            strobe_ff <= nxt_strobe;
        end
    end

    // ************************************************************
    // Debounce counter
    // ************************************************************
    // Counts ticks of continuous external low; any bounce restarts it.
    // Tick granularity means a press is accepted one tick early at worst.
    always_comb begin
        nxt_deb = deb_ff;
        if (!ext_low) begin
            nxt_deb = '0;                                              // RULE3
        end else if (tk.tick && !deb_done) begin
            nxt_deb = deb_ff + 20'h00001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            deb_ff <= '0;
        end else begin
            deb_ff <= nxt_deb;
        end
    end

    // ************************************************************
    // Watchdog counter
    // ************************************************************
    // Idles during reset so the host gets a full period afterwards
    always_comb begin
        nxt_wdt = wdt_ff;
        if (state_ff != cpusr_pkg::CPUSR_RUN || strobe_fall) begin
            nxt_wdt = '0;                                              // RULE7
        end else if (tk.tick && !wdt_done) begin
            nxt_wdt = wdt_ff + 20'h00001;                              // RULE4
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wdt_ff <= '0;
        end else begin
            wdt_ff <= nxt_wdt;
        end
    end

    // ************************************************************
    // Reset sequencer
    // ************************************************************
    // HOLD: supply fault present; RELEASE: timed 250 ms hold before letting go.
    // Supply fault wins over every other cause, even mid-hold, and sends
    // the sequencer back to HOLD so the full hold restarts on recovery.
    // Press and watchdog only start a reset from RUN; during a reset they
    // add nothing, since the pin is already low.
    always_comb begin
        nxt_state = state_ff;
        nxt_hold  = hold_ff;
        nxt_drive = drive_ff;
        unique case (state_ff)
            cpusr_pkg::CPUSR_RUN: begin
                nxt_drive = 1'b0;
                if (supply_fail) begin
                    nxt_state = cpusr_pkg::CPUSR_HOLD;                 // RULE1
                    nxt_drive = 1'b1;
                end else if (press || wdt_expire) begin
                    nxt_state = cpusr_pkg::CPUSR_RELEASE;              // RULE3 RULE4
                    nxt_hold  = '0;
                    nxt_drive = 1'b1;
                end
            end
            cpusr_pkg::CPUSR_HOLD: begin
                nxt_drive = 1'b1;                                      // RULE1
                if (!supply_fail) begin
                    nxt_state = cpusr_pkg::CPUSR_RELEASE;              // RULE2
                    nxt_hold  = '0;
                end
            end
            cpusr_pkg::CPUSR_RELEASE: begin
                nxt_drive = 1'b1;
                if (supply_fail) begin
                    nxt_state = cpusr_pkg::CPUSR_HOLD;                 // RULE1
                end else if (hold_done) begin
                    nxt_state = cpusr_pkg::CPUSR_RUN;                  // RULE2
                    nxt_drive = 1'b0;
                end else if (tk.tick) begin
                    nxt_hold = hold_ff + 20'h00001;
                end
            end
        endcase
    end

    // Power-on is treated like a supply recovery: full hold after release
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= cpusr_pkg::CPUSR_RELEASE;
            hold_ff  <= '0;
            drive_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            hold_ff  <= nxt_hold;
            drive_ff <= nxt_drive;
        end
    end

    // ************************************************************
    // Open-drain pin
    // ************************************************************
    // Data is a constant low: the pin is only ever pulled down, the pull-up
    // outside gives the high level, so other parties can share the wire
    assign rst_pin_data = 1'b0;                                        // RULE6
    assign rst_pin_oe   = drive_ff;                                    // RULE6
    assign reset_active = drive_ff;
endmodule : cpusr_supervisor

// [design/cpusr_tick_div.sv]
/*
 * Divider that makes a one-cycle enable at the slow supervisor timebase.
 * Assumes mclk at the package rate and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module cpusr_tick_div (
    input  wire logic   mclk,
    input  wire logic   rst_n,
    cpusr_tick_if.src   tk
);
    logic [cpusr_pkg::TICK_W-1:0] div_ff;
    logic [cpusr_pkg::TICK_W-1:0] nxt_div;
    logic                         tick_ff;
    logic                         nxt_tick;

    // ************************************************************
    // Divider
    // ************************************************************
    // Wrap and pulse once per timebase period
    always_comb begin
        nxt_tick = 1'b0;
        nxt_div  = div_ff + 12'h001;
        if (div_ff == cpusr_pkg::TICK_W'(cpusr_pkg::TICK_DIV - 1)) begin
            nxt_div  = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

    assign tk.tick = tick_ff;
endmodule : cpusr_tick_div

// [design/cpusr_tick_if.sv]
/*
 * Carrier for the timebase enable pulse between the divider and the core.
 * Assumes both ends share mclk.
 */
`timescale 1ns/1ps
interface cpusr_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input  tick);
endinterface : cpusr_tick_if

// [verification/cpusr_host_model.sv]
/* Host processor and pushbutton on the shared reset wire.
 * Assumes the wire has a pull-up and the host halts while held in reset. */
`timescale 1ns/1ps
module cpusr_host_model (
    input  wire logic mclk,
    input  wire logic oe,
    input  wire logic btn,
    input  wire logic strobe_en,
    output logic      wdt_strobe,
    output logic      pin_lvl
);
    int ph = 0;
    // Pull-up wire: low if either party pulls
    assign pin_lvl = !(oe || btn);
    // Strobe falls every 1000 cycles, well inside the timeout; frozen in reset
    initial wdt_strobe = 1'b1;
    always @(negedge mclk) begin
        ph = (ph + 1) % 500;
        if (strobe_en && pin_lvl && ph == 0) wdt_strobe <= !wdt_strobe;
    end
endmodule : cpusr_host_model

// [verification/cpusr_supervisor_sva.sv]
/* Checker for the supervisor reset ports.
 * Assumes one mclk domain and sync active-low rst_n. */
`timescale 1ns/1ps
module cpusr_supervisor_sva #(
    parameter logic [19:0] WDT_TICKS  = 20'h0,
    parameter logic [19:0] HOLD_TICKS = 20'h0,
    parameter logic [19:0] DEB_TICKS  = 20'h0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic supply_fail,
    input wire logic wdt_strobe,
    input wire logic rst_pin_level,
    input wire logic rst_pin_data,
    input wire logic rst_pin_oe,
    input wire logic reset_active
);
    // ****
    // Cycles since supply or reset last active, saturating
    // ****
    int unsigned quiet_ff;
    always_ff @(posedge mclk) begin
        quiet_ff <= (!rst_n || supply_fail) ? 0 : (quiet_ff < 1000000 ? quiet_ff + 1 : quiet_ff);
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_fail_drives_pin: assert property (supply_fail |=> rst_pin_oe)
        else $error("supply fault did not pull reset");
    a_fail_keeps_pin: assert property (rst_pin_oe && supply_fail |=> rst_pin_oe)
        else $error("reset dropped during supply fault");
    a_recover_stays: assert property ($fell(supply_fail) |-> rst_pin_oe [*8])
        else $error("reset dropped at supply recovery");
    a_release_after_hold: assert property ($fell(rst_pin_oe) |->
        quiet_ff >= (int'(HOLD_TICKS) - 1) * cpusr_pkg::TICK_DIV)
        else $error("reset released before hold time");
    a_pulse_min_len: assert property ($rose(rst_pin_oe) |=> rst_pin_oe [*8])
        else $error("reset pulse too short");
    a_strobe_keeps_run: assert property ($fell(wdt_strobe) && rst_pin_level && !rst_pin_oe && !supply_fail
        |=> !rst_pin_oe)
        else $error("reset raised right after strobe");
    a_drain_low_only: assert property (rst_pin_data == 1'b0)
        else $error("open-drain data not low");
    a_active_mirror: assert property (reset_active == rst_pin_oe)
        else $error("reset_active differs from pin enable");
endmodule : cpusr_supervisor_sva
bind cpusr_supervisor cpusr_supervisor_sva #(.WDT_TICKS(WDT_TICKS), .HOLD_TICKS(HOLD_TICKS),
    .DEB_TICKS(DEB_TICKS)) i_sva (.mclk(mclk), .rst_n(rst_n), .supply_fail(supply_fail),
    .wdt_strobe(wdt_strobe), .rst_pin_level(rst_pin_level), .rst_pin_data(rst_pin_data),
    .rst_pin_oe(rst_pin_oe), .reset_active(reset_active));

// [verification/test_cpusr_supervisor.sv]
/* Self-checking bench: reset lengths measured in cycles against tick model.
 * Assumes the host model file and the checker are compiled alongside. */
`timescale 1ns/1ps
module test_cpusr_supervisor;
    localparam int TD = cpusr_pkg::TICK_DIV;
    localparam int HT = 3, DT = 2, WT = 4;
    logic mclk = 0, rst_n = 0, supply_fail = 0, btn = 0, strobe_en = 1;
    logic wdt_strobe, pin_lvl, rst_pin_data, rst_pin_oe, reset_active;
    int   error_cnt = 0, check_count = 0, seed = 75, n;
    always #5 mclk = !mclk;
    // Short counts keep the run near 80k cycles
    cpusr_supervisor #(.WDT_TICKS(20'(WT)), .HOLD_TICKS(20'(HT)), .DEB_TICKS(20'(DT))) i_dut (
        .mclk(mclk), .rst_n(rst_n), .supply_fail(supply_fail), .wdt_strobe(wdt_strobe),
        .rst_pin_level(pin_lvl), .rst_pin_data(rst_pin_data), .rst_pin_oe(rst_pin_oe),
        .reset_active(reset_active));
    cpusr_host_model i_host (.mclk(mclk), .oe(rst_pin_oe), .btn(btn), .strobe_en(strobe_en),
        .wdt_strobe(wdt_strobe), .pin_lvl(pin_lvl));
    // Bounded wait; a timeout returns lim, which glitch and alive expect and the other range checks reject
    task automatic wait_lvl(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (reset_active !== v && cnt < lim) begin
            @(negedge mclk);
            cnt++;
        end
    endtask : wait_lvl
    task automatic chk(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
        $display("test %s done", what);
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(negedge mclk);
        rst_n = 1;
        wait_lvl(0, 9 * TD, n);
        chk("powerup", (HT - 1) * TD, (HT + 1) * TD + 5, n);
        repeat (100 + $unsigned($random(seed)) % 400) @(negedge mclk);
        supply_fail = 1;
        wait_lvl(1, 3, n);
        chk("fail", 1, 1, n);
        repeat (300) @(negedge mclk);
        supply_fail = 0;
        wait_lvl(0, 9 * TD, n);
        chk("supply", (HT - 1) * TD, (HT + 1) * TD + 5, n);
        btn = 1;
        repeat (5) @(negedge mclk);
        btn = 0;
        wait_lvl(1, 3 * TD, n);
        chk("glitch", 3 * TD, 3 * TD, n);
        btn = 1;
        wait_lvl(1, 9 * TD, n);
        chk("debounce", (DT - 1) * TD, (DT + 1) * TD + 5, n);
        repeat (10) @(negedge mclk);
        btn = 0;
        wait_lvl(0, 9 * TD, n);
        chk("press", (HT - 1) * TD - 10, (HT + 1) * TD, n);
        wait_lvl(1, (WT + 2) * TD, n);
        chk("alive", (WT + 2) * TD, (WT + 2) * TD, n);
        strobe_en = 0;
        wait_lvl(1, 9 * TD, n);
        chk("expire", (WT - 2) * TD, (WT + 1) * TD + 5, n);
        strobe_en = 1;
        wait_lvl(0, 9 * TD, n);
        chk("dog_hold", (HT - 1) * TD, (HT + 1) * TD + 5, n);
        tally_and_finish();
    end
endmodule : test_cpusr_supervisor
